// file: wake_source_detect.sv
// Top of the standby wake-source detector for four external inputs.
// Assumes pins synchronous to sys_clk and a simple strobe register port.
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/100ps

module wake_source_detect (
    // Clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   arst_n,
    // Register port
    input  wire logic [7:0]             regAddr,
    input  wire logic [31:0]            regWdata,
    input  wire logic                   regWr,
    input  wire logic                   regRd,
    output logic [31:0]                 regRdata,
    // External interrupt inputs
    input  wire logic                   ext_irq_in_0,
    input  wire logic                   ext_irq_in_1,
    input  wire logic                   ext_irq_in_2,
    input  wire logic                   ext_irq_in_3,
    // Wake and interrupt outputs
    output logic                        standbyClearReq,
    output logic                        irqOut
);

    // ------------------------------------------------------------------
    // Address decode helper
    // ------------------------------------------------------------------

    // Full-width compare; the low two bits must be zero for a hit, so
    // unaligned accesses fall into the unmapped space.
    function automatic logic addrIs(input logic [7:0] a,
                                    input logic [7:0] off);
        addrIs = (a == off);
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------

    // Gathered pins, one bit per channel.
    logic [3:0]                         pinVec;

    // Mode and enable fields per channel, as written by software.
    logic [2:0]                         chMode_reg   [4];
    logic [3:0]                         chEnable_reg;

    // Configuration packed for each channel instance.
    wake_detect_pkg::ch_cfg_s           chCfg        [4];

    // Channel results.
    logic [3:0]                         chHit;
    logic [3:0]                         chPending;
    logic [1:0]                         chEdge       [4];

    // One-cycle clear pulses toward the channels.
    logic [3:0]                         pendClear;

    // Interrupt status and mask.
    logic [3:0]                         irqStat_reg;
    logic [3:0]                         irqMask_reg;

    // Decoded accesses.
    logic                               wrMode;
    logic                               wrClear;
    logic                               wrMask;
    logic                               rdStat;

    // Read data and its next value.
    logic [31:0]                        rdData_reg;
    logic [31:0]                        rdData_next;

    // Assembled control word for read-back.
    logic [31:0]                        modeWord;

    // ------------------------------------------------------------------
    // Pin gathering
    // ------------------------------------------------------------------

    // The pins are taken as already synchronous to sys_clk; a board with
    // asynchronous sources must add synchronisers in front of this block.
    assign pinVec = {ext_irq_in_3, ext_irq_in_2, ext_irq_in_1, ext_irq_in_0};

    // ------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------

    // Each strobe is one cycle wide, so each decoded term is too.
    assign wrMode  = regWr & addrIs(regAddr, wake_detect_pkg::OFF_MODE_A);
    assign wrClear = regWr & addrIs(regAddr, wake_detect_pkg::OFF_PEND_CLR);
    assign wrMask  = regWr & addrIs(regAddr, wake_detect_pkg::OFF_IRQ_MASK);
    assign rdStat  = regRd & addrIs(regAddr, wake_detect_pkg::OFF_IRQ_STAT);

    // ------------------------------------------------------------------
    // Mode and enable fields
    // ------------------------------------------------------------------

    // One lane per channel. Mode and enable are stored from the write
    // data; status bits in the same lane are not stored at all.
    generate
        for (genvar ch = 0; ch < wake_detect_pkg::NUM_CH; ch++) begin : g_cfg

            // Bit offset of this channel's byte lane.
            localparam int Base = ch * wake_detect_pkg::CH_STRIDE;

            // Mode field: reset value is falling edge.
            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    chMode_reg[ch] <= wake_detect_pkg::MODE_RESET;
                end else if (wrMode) begin
                    // Stored as written; prohibited codes simply detect
                    // nothing downstream.
                    chMode_reg[ch] <= regWdata[Base + wake_detect_pkg::MODE_LSB +: 3];
                end
            end

            // Enable bit: reset value is disabled.
            // Both fields land in one write if software sends them so;
            // the hardware does not police the ordering, and a same-write
            // enable takes effect in the same cycle as the new mode.
            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    chEnable_reg[ch] <= 1'b0;
                end else if (wrMode) begin
                    chEnable_reg[ch] <= regWdata[Base + wake_detect_pkg::EN_BIT];
                end
            end

            // Pack the channel's configuration.
            assign chCfg[ch].mode   = chMode_reg[ch];
            assign chCfg[ch].enable = chEnable_reg[ch];

            // Clear pulse: one bit of wake_pending_clear per channel.
            assign pendClear[ch] = wrClear & regWdata[ch];

            // Per-channel detector with pending flag and edge status.
            wake_channel_detect u_ch (
                .sys_clk    (sys_clk),
                .arst_n     (arst_n),
                .pinIn      (pinVec[ch]),
                .cfg        (chCfg[ch]),
                .clearReq   (pendClear[ch]),
                .hit        (chHit[ch]),
                .pending    (chPending[ch]),
                .edgeStatus (chEdge[ch])
            );

        end
    endgenerate

    // ------------------------------------------------------------------
    // Control word assembly
    // ------------------------------------------------------------------

    // Rebuild wake_source_mode_a for reads. Status fields come from the
    // channels, never from write data. Unused bits read as zero.
    always_comb begin
        modeWord = wake_detect_pkg::ZERO_WORD;
        for (int ch = 0; ch < wake_detect_pkg::NUM_CH; ch++) begin
            modeWord[ch * wake_detect_pkg::CH_STRIDE + wake_detect_pkg::MODE_LSB +: 3]
                = chMode_reg[ch];
            modeWord[ch * wake_detect_pkg::CH_STRIDE + wake_detect_pkg::STAT_LSB +: 2]
                = chEdge[ch];
            modeWord[ch * wake_detect_pkg::CH_STRIDE + wake_detect_pkg::EN_BIT]
                = chEnable_reg[ch];
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------------

    // Sticky status: each channel hit sets its bit. A read of the status
    // register clears it, but a hit in that same cycle survives the read.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irqStat_reg <= 4'h0;
        end else begin
            irqStat_reg <= chHit | (irqStat_reg & {4{~rdStat}});
        end
    end

    // Mask: a one lets the matching status bit reach irqOut.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irqMask_reg <= 4'h0;
        end else if (wrMask) begin
            irqMask_reg <= regWdata[3:0];
        end
    end

    // Level interrupt: high while any unmasked status bit is set.
    assign irqOut = |(irqStat_reg & irqMask_reg);

    // ------------------------------------------------------------------
    // Standby clear request
    // ------------------------------------------------------------------

    // The wake request stands as long as any channel is pending, so the
    // standby logic cannot miss a short pulse; software ends it through
    // wake_pending_clear.
    assign standbyClearReq = |chPending;

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------

    // Select read data; unmapped addresses answer zero.
    always_comb begin
        rdData_next = wake_detect_pkg::ZERO_WORD;
        if (regRd) begin
            case (regAddr)
                wake_detect_pkg::OFF_MODE_A: begin
                    rdData_next = modeWord;
                end
                wake_detect_pkg::OFF_PENDING: begin
                    rdData_next[3:0] = chPending;
                end
                wake_detect_pkg::OFF_IRQ_STAT: begin
                    rdData_next[3:0] = irqStat_reg;
                end
                wake_detect_pkg::OFF_IRQ_MASK: begin
                    rdData_next[3:0] = irqMask_reg;
                end
                // The clear register is write-only and reads zero.
                default: begin
                    rdData_next = wake_detect_pkg::ZERO_WORD;
                end
            endcase
        end
    end

    // Read data stands in the cycle after the strobe and only there;
    // otherwise the bus sees zero.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdData_reg <= wake_detect_pkg::ZERO_WORD;
        end else begin
            rdData_reg <= rdData_next;
        end
    end

    assign regRdata = rdData_reg;

endmodule // wake_source_detect

// file: wake_detect_pkg.sv
// Package for the standby wake-source detector.
// Holds register offsets, field layout, reset values and mode codes.
// Assumes a byte-addressed register port with one aligned word per register.

package wake_detect_pkg;

    // ------------------------------------------------------------------
    // Register port geometry
    // ------------------------------------------------------------------
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam int          NUM_CH          = 4;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0]  OFF_MODE_A      = 8'h00;   // wake_source_mode_a
    localparam logic [7:0]  OFF_PEND_CLR    = 8'h04;   // wake_pending_clear
    localparam logic [7:0]  OFF_PENDING     = 8'h08;   // Pending wake state
    localparam logic [7:0]  OFF_IRQ_STAT    = 8'h0C;   // Sticky event status
    localparam logic [7:0]  OFF_IRQ_MASK    = 8'h10;   // Event mask

    // ------------------------------------------------------------------
    // Field layout inside wake_source_mode_a, one byte lane per channel
    // ------------------------------------------------------------------
    localparam int          CH_STRIDE       = 8;       // Bits per channel lane.
    localparam int          MODE_LSB        = 4;       // Mode field bits 6-4.
    localparam int          MODE_W          = 3;
    localparam int          STAT_LSB        = 2;       // Edge status bits 3-2.
    localparam int          STAT_W          = 2;
    localparam int          EN_BIT          = 0;       // Wake enable bit 0.

    // ------------------------------------------------------------------
    // Detection-mode codes and reset values
    // ------------------------------------------------------------------
    localparam logic [2:0]  MODE_LOW        = 3'h0;
    localparam logic [2:0]  MODE_HIGH       = 3'h1;
    localparam logic [2:0]  MODE_FALL       = 3'h2;
    localparam logic [2:0]  MODE_RISE       = 3'h3;
    localparam logic [2:0]  MODE_BOTH       = 3'h4;
    localparam logic [2:0]  MODE_RESET      = 3'h2;    // Falling edge after reset.

    // Edge-status codes: bit 0 rising seen, bit 1 falling seen.
    localparam logic [1:0]  STAT_NONE       = 2'h0;
    localparam logic [1:0]  STAT_RISE       = 2'h1;
    localparam logic [1:0]  STAT_FALL       = 2'h2;
    localparam logic [1:0]  STAT_BOTH       = 2'h3;

    localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Per-channel configuration carried from the register file
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] mode;      // Detection mode code.
        logic       enable;    // Wake enable.
    } ch_cfg_s;

endpackage

// file: wake_channel_detect.sv
// One wake channel: level/edge detector, pending flag and edge status.
// Assumes the pin is already synchronous to sys_clk.
`timescale 1ns/100ps

module wake_channel_detect (
    // Clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     arst_n,
    // Pin and configuration
    input  wire logic                     pinIn,
    input  wake_detect_pkg::ch_cfg_s      cfg,
    input  wire logic                     clearReq,
    // Results
    output logic                          hit,
    output logic                          pending,
    output logic [1:0]                    edgeStatus
);

    // ------------------------------------------------------------------
    // Edge history
    // ------------------------------------------------------------------
    logic pinPrev_reg;    // Pin value one cycle ago.
    logic primed_reg;     // High once a valid previous sample exists.
    logic rise;
    logic fall;
    logic match;

    // Remember the last sample; edges before the first sample are ignored
    // so that a pin held high across reset does not fake a rising edge.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pinPrev_reg <= 1'b0;
            primed_reg  <= 1'b0;
        end else begin
            pinPrev_reg <= pinIn;
            primed_reg  <= 1'b1;
        end
    end

    assign rise = primed_reg & pinIn & ~pinPrev_reg;
    assign fall = primed_reg & ~pinIn & pinPrev_reg;

    // Select the condition named by the mode field.
    always_comb begin
        case (cfg.mode)
            wake_detect_pkg::MODE_LOW:  match = ~pinIn;
            wake_detect_pkg::MODE_HIGH: match = pinIn;
            wake_detect_pkg::MODE_FALL: match = fall;
            wake_detect_pkg::MODE_RISE: match = rise;
            wake_detect_pkg::MODE_BOTH: match = rise | fall;
            // Prohibited codes detect nothing.
            default:                    match = 1'b0;
        endcase
    end

    // A disabled channel never raises a wake request.
    assign hit = cfg.enable & match;

    // Pending flag: a new hit wins over a clear in the same cycle.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pending <= 1'b0;
        end else begin
            pending <= hit | (pending & ~clearReq);
        end
    end

    // Edge status records only in both-edges mode; cleared with pending.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            edgeStatus <= wake_detect_pkg::STAT_NONE;
        end else begin
            edgeStatus <= (clearReq ? wake_detect_pkg::STAT_NONE : edgeStatus)
                        | ((hit && cfg.mode == wake_detect_pkg::MODE_BOTH)
                           ? {fall, rise} : wake_detect_pkg::STAT_NONE);
        end
    end

endmodule // wake_channel_detect

// file: wake_pin_model.sv
// Model of the four external wake pins that face the detector.
// Assumes the detector takes its pins as already synchronous to sys_clk.
`timescale 1ns/100ps

module wake_pin_model (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    // Levels asked for by the bench
    input  wire logic [3:0] pinCmd,
    // Pins
    output logic            ext_irq_in_0,
    output logic            ext_irq_in_1,
    output logic            ext_irq_in_2,
    output logic            ext_irq_in_3
);
    // Pins move one edge after the request, as a synchroniser would.
    // This keeps every pin change clear of the edge that samples it.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            {ext_irq_in_3, ext_irq_in_2, ext_irq_in_1, ext_irq_in_0} <= 4'h0;
        end else begin
            {ext_irq_in_3, ext_irq_in_2, ext_irq_in_1, ext_irq_in_0} <= pinCmd;
        end
    end
endmodule // wake_pin_model

// file: wake_source_detect_asserts.sv
// Concurrent checks on the ports of the wake-source detector.
// Assumes one clock domain and the register map of the package.
`timescale 1ns/100ps

module wake_source_detect_asserts (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    // Register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    input  wire logic [31:0] regRdata,
    // Pins and outputs
    input  wire logic        ext_irq_in_0,
    input  wire logic        ext_irq_in_1,
    input  wire logic        ext_irq_in_2,
    input  wire logic        ext_irq_in_3,
    input  wire logic        standbyClearReq,
    input  wire logic        irqOut
);
    // Decode helpers keep the properties short.
    logic isMapped;
    logic rdMode;
    logic rdClr;
    logic rdPend;
    logic rdStat;
    logic wrClr;
    logic wrMask;
    assign isMapped = regAddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
    assign rdMode   = regRd && (regAddr == wake_detect_pkg::OFF_MODE_A);
    assign rdClr    = regRd && (regAddr == wake_detect_pkg::OFF_PEND_CLR);
    assign rdPend   = regRd && (regAddr == wake_detect_pkg::OFF_PENDING);
    assign rdStat   = regRd && (regAddr == wake_detect_pkg::OFF_IRQ_STAT);
    assign wrClr    = regWr && (regAddr == wake_detect_pkg::OFF_PEND_CLR);
    assign wrMask   = regWr && (regAddr == wake_detect_pkg::OFF_IRQ_MASK);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    a_rdata_idle_zero: assert property (!$past(regRd) |-> regRdata == 32'h0000_0000)
        else $error("Read data not zero outside a read answer.");
    a_unmapped_read_zero: assert property (($past(regRd) && !$past(isMapped)) |-> regRdata == 0)
        else $error("Unmapped read returned data.");
    a_mode_spare_zero: assert property ($past(rdMode) |-> (regRdata & 32'h8282_8282) == 0)
        else $error("Spare mode bits read nonzero.");
    a_clr_reads_zero: assert property ($past(rdClr) |-> regRdata == 0)
        else $error("Clear register read nonzero.");
    a_pend_tracks_req: assert property ($past(rdPend) |->
        (regRdata[31:4] == 0) && ((|regRdata[3:0]) == $past(standbyClearReq)))
        else $error("Pending flags disagree with the wake request.");
    a_irq_has_status: assert property ($past(rdStat && irqOut) |-> regRdata[3:0] != 4'h0)
        else $error("Interrupt high with no status bit.");
    a_req_fall_clear: assert property ($fell(standbyClearReq) |->
        $past(wrClr) || $past(wrClr, 2))
        else $error("Wake request dropped without a clear write.");
    a_irq_fall_cause: assert property ($fell(irqOut) |->
        $past(rdStat || wrMask) || $past(rdStat || wrMask, 2))
        else $error("Interrupt dropped without status read or mask write.");
endmodule // wake_source_detect_asserts

bind wake_source_detect wake_source_detect_asserts i_chk (.sys_clk(sys_clk), .arst_n(arst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .ext_irq_in_0(ext_irq_in_0), .ext_irq_in_1(ext_irq_in_1),
    .ext_irq_in_2(ext_irq_in_2), .ext_irq_in_3(ext_irq_in_3),
    .standbyClearReq(standbyClearReq), .irqOut(irqOut));

// file: wake_source_detect_tb.sv
// Self-checking bench for the wake-source detector.
// Assumes the pin model and the checker are compiled before this file.
`timescale 1ns/100ps

module wake_source_detect_tb;
    // ------------------------------------------------------------------
    // Drives, outputs and bookkeeping
    // ------------------------------------------------------------------
    logic        sys_clk  = 1'b0;
    logic        arst_n   = 1'b0;
    logic [7:0]  regAddr  = 8'h00;
    logic [31:0] regWdata = 32'h0000_0000;
    logic        regWr    = 1'b0;
    logic        regRd    = 1'b0;
    logic [3:0]  pinCmd   = 4'h0;
    logic [31:0] regRdata;
    logic        standbyClearReq;
    logic        irqOut;
    logic [3:0]  pins;
    int          n_errors = 0;
    int          n_tests  = 0;
    int          cycles   = 0;

    always #20 sys_clk = ~sys_clk;

    wake_pin_model i_wake_pin_model (.sys_clk(sys_clk), .arst_n(arst_n), .pinCmd(pinCmd),
        .ext_irq_in_0(pins[0]), .ext_irq_in_1(pins[1]), .ext_irq_in_2(pins[2]),
        .ext_irq_in_3(pins[3]));
    wake_source_detect i_wake_source_detect (.sys_clk(sys_clk), .arst_n(arst_n),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .ext_irq_in_0(pins[0]), .ext_irq_in_1(pins[1]),
        .ext_irq_in_2(pins[2]), .ext_irq_in_3(pins[3]),
        .standbyClearReq(standbyClearReq), .irqOut(irqOut));

    // ------------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One-cycle write strobe; the gap before the next strobe avoids a double drive.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge sys_clk);
        regWr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample mid-cycle.
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRd   <= 1'b0;
        @(negedge sys_clk);
        check(regRdata, exp);
    endtask

    task automatic flags(input logic req, input logic irq);
        @(negedge sys_clk);
        check({30'h0, standbyClearReq, irqOut}, {30'h0, req, irq});
    endtask

    // Pin reaches the detector one edge later, the result one edge after that.
    task automatic pin(input int c, input logic v);
        @(posedge sys_clk);
        pinCmd[c] <= v;
        repeat (3) @(posedge sys_clk);
    endtask

    // One detection mode on one channel, from disabled through wake and clear.
    task automatic modeStep(input logic [2:0] m, input int c);
        int          sh;
        logic        idle;
        logic [31:0] lane;
        logic [31:0] en;
        logic [31:0] bit1;
        sh   = 8 * c;
        idle = (m == wake_detect_pkg::MODE_LOW) || (m == wake_detect_pkg::MODE_FALL);
        lane = {29'h0, m} << (sh + 4);
        en   = 32'h0000_0001 << sh;
        bit1 = 32'h0000_0001 << c;
        pin(c, idle);
        wr(wake_detect_pkg::OFF_MODE_A, lane);
        wr(wake_detect_pkg::OFF_PEND_CLR, 32'h0000_000F);
        pin(c, !idle);
        rd(wake_detect_pkg::OFF_PENDING, 32'h0000_0000);
        wr(wake_detect_pkg::OFF_MODE_A, lane | en); // Enable in its own later write.
        pin(c, idle);
        wr(wake_detect_pkg::OFF_PEND_CLR, 32'h0000_000F);
        rd(wake_detect_pkg::OFF_PENDING, 32'h0000_0000);
        rd(wake_detect_pkg::OFF_MODE_A, lane | en);
        // Single-edge modes ignore the return to idle; level modes hit at the enable, both-edge mode on the return.
        rd(wake_detect_pkg::OFF_IRQ_STAT, (m[2] | ~m[1]) ? bit1 : 0);
        pin(c, !idle);
        rd(wake_detect_pkg::OFF_PENDING, bit1);
        flags(1'b1, 1'b1);
        wr(wake_detect_pkg::OFF_IRQ_MASK, 32'h0000_0000);
        flags(1'b1, 1'b0);
        wr(wake_detect_pkg::OFF_IRQ_MASK, 32'h0000_000F);
        pin(c, idle);
        rd(wake_detect_pkg::OFF_MODE_A, lane | en | ((m[2]) ? 32'hC << sh : 0));
        rd(wake_detect_pkg::OFF_IRQ_STAT, bit1);
        rd(wake_detect_pkg::OFF_IRQ_STAT, 32'h0000_0000);
        flags(1'b1, 1'b0);
        wr(wake_detect_pkg::OFF_PEND_CLR, bit1);
        rd(wake_detect_pkg::OFF_MODE_A, lane | en);
        flags(1'b0, 1'b0);
        wr(wake_detect_pkg::OFF_MODE_A, lane);
        $display("test mode %0d on channel %0d done", m, c);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if ((n_errors == 0) && (n_tests > 0)) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // The whole run needs well under a thousand cycles.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            $display("[ERR] %0t run did not finish", $time);
            end_of_test();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (4) @(posedge sys_clk);
        arst_n <= 1'b1;
        rd(wake_detect_pkg::OFF_MODE_A, 32'h2020_2020);
        rd(wake_detect_pkg::OFF_PENDING, 32'h0000_0000);
        rd(wake_detect_pkg::OFF_IRQ_STAT, 32'h0000_0000);
        rd(wake_detect_pkg::OFF_IRQ_MASK, 32'h0000_0000);
        rd(wake_detect_pkg::OFF_PEND_CLR, 32'h0000_0000);
        rd(8'h14, 32'h0000_0000);
        flags(1'b0, 1'b0);
        $display("test reset and map done");
        wr(wake_detect_pkg::OFF_MODE_A, 32'h4C4C_4C4C);
        rd(wake_detect_pkg::OFF_MODE_A, 32'h4040_4040);
        wr(wake_detect_pkg::OFF_IRQ_MASK, 32'h0000_000F);
        rd(wake_detect_pkg::OFF_IRQ_MASK, 32'h0000_000F);
        $display("test read-only status done");
        for (int m = 0; m < 5; m++) begin // Only codes 000 to 100 are written.
            modeStep(m[2:0], m % 4);
        end
        end_of_test();
    end
endmodule // wake_source_detect_tb
